// file: bench/raw_sample_debug_serializer_tb.sv
// Self-checking bench for the raw sample debug serializer.
// Assumes the capture model sits on the port pins; inputs change 1 ns after a rising edge.
`default_nettype none
module raw_sample_debug_serializer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rrdbg_pkg::*;
   logic clk, nrst, sample_valid, sample_ready, bclk, frm;
   logic [SAMPLE_W-1:0] sample_data;
   logic [1:0] rate_sel;
   logic [LANES-1:0] lanes;
   logic [FRAME_W-1:0] word;
   int frames, last_len, faults, n_fail, checked, cyc;

   rrdbg_serializer dut (.clk(clk), .nrst(nrst), .sample_data(sample_data),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .rate_sel(rate_sel),
      .port_bit_clock_pin(bclk), .frame_clock_pin(frm), .sample_data_lanes(lanes));
   rrdbg_capture cap (.nrst(nrst), .bclk(bclk), .frm(frm), .lanes(lanes), .word(word),
      .frames(frames), .last_len(last_len), .faults(faults));

   task check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task finish_test;
      if (n_fail == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Leaves valid high so back-to-back pushes never touch it twice in one step
   task push(input logic [SAMPLE_W-1:0] d);
      sample_data = d;
      sample_valid = 1'b1;
      for (int k = 0; k < 200; k++) begin
         @(negedge clk);
         if (sample_ready === 1'b1) break;
      end
      @(posedge clk);
      #1;
   endtask
   task wait_frames(input int n);
      for (int k = 0; k < 400 && frames < n; k++) @(negedge clk);
      @(posedge clk);
      #1;
   endtask
   // Two frames queued at once: words, mapping and frame spacing per rate
   task run_pair(input logic [1:0] rate, input int span);
      logic [FRAME_W-1:0] w [2];
      logic [SAMPLE_W-1:0] s;
      int f0;
      f0 = frames;
      rate_sel = rate;
      for (int i = 0; i < 8; i++) begin
         s = {i[3:0], rate, 6'h35} ^ 12'h9c0;
         w[i/4] = {w[i/4][FRAME_W-SAMPLE_W-1:0], s};
         push(s);
      end
      sample_valid = 1'b0;
      wait_frames(f0 + 1);
      check(word, w[0]);
      wait_frames(f0 + 2);
      check(word, w[1]);
      check(last_len, span);
      check(faults, 0);
   endtask
   // No traffic: bit clock keeps running, lanes and frame clock rest low
   task idle_check;
      logic prev;
      int tog;
      repeat (80) @(negedge clk);
      prev = bclk;
      tog = 0;
      for (int k = 0; k < 40; k++) begin
         @(negedge clk);
         if (bclk !== prev) tog++;
         prev = bclk;
         check({frm, lanes}, 5'h00);
      end
      check(tog, 20);
   endtask
   // Reset in a frame's first slot drops the frame and clears the pins
   task reset_mid;
      @(posedge clk);
      #1;
      push(12'h5a3);
      push(12'h0ff);
      push(12'hc81);
      push(12'h347);
      sample_valid = 1'b0;
      check(sample_ready, 1'b0);
      for (int k = 0; k < 100 && frm !== 1'b1; k++) @(posedge clk);
      #1;
      check(sample_ready, 1'b1);
      nrst = 1'b0;
      #1;
      check({bclk, frm, lanes}, 6'h00);
      repeat (3) @(posedge clk);
      #1;
      nrst = 1'b1;
      repeat (100) @(posedge clk);
      #1;
      check(frames, 0);
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      nrst = 1'b0;
      sample_data = '0;
      sample_valid = 1'b0;
      rate_sel = 2'h0;
      repeat (10) @(posedge clk);
      #1;
      nrst = 1'b1;
      run_pair(2'h0, 12);
      run_pair(2'h1, 16);
      run_pair(2'h2, 24);
      run_pair(2'h3, 30);
      idle_check();
      reset_mid();
      run_pair(2'h0, 12);
      finish_test();
   end
endmodule
`default_nettype wire

// file: bench/rrdbg_capture.sv
// Capture model of the external debug receiver for the raw sample port.
// Assumes it sees the port pins directly; it samples on both bit clock edges.
`default_nettype none
module rrdbg_capture
   import rrdbg_pkg::*;
(
   // Reset
   input wire logic nrst,
   // Port pins
   input wire logic bclk,
   input wire logic frm,
   input wire logic [LANES-1:0] lanes,
   // Results
   output logic [FRAME_W-1:0] word,
   output int frames,
   output int last_len,
   output int faults
);
   int edges, cnt, start_edge;
   logic [FRAME_W-1:0] sh;
   always @(bclk or negedge nrst) begin
      if (!nrst) begin
         edges = 0; cnt = 0; start_edge = 0; frames = 0; last_len = 0; faults = 0;
         word = '0; sh = '0;
      end else begin
         edges++;
         // Only framed edges are taken; gaps are skipped
         if (cnt != 0 || frm) begin
            if (cnt == 0) begin
               if (!bclk) faults++;
               last_len = edges - start_edge;
               start_edge = edges;
            end
            if (frm !== (cnt < FRAME_HIGH_EDGES)) faults++;
            sh = {sh[FRAME_W-LANES-1:0], lanes};
            cnt++;
            if (cnt == EDGES_PER_FRAME) begin
               cnt = 0;
               word = sh;
               frames++;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: hw/rrdbg_lane_mux.sv
// Picks the four lane bits for one bit clock edge out of a 48-bit frame word.
// Assumes edge_idx stays below the frame length; larger values give zero.
`default_nettype none
module rrdbg_lane_mux
   import rrdbg_pkg::*;
(
   // Frame word and edge select
   rrdbg_lane_if.mux lm
);
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         // Most significant nibble on the first edge, lane 3 carries the top bit
         always_comb begin
            if (lm.edge_idx < 4'(EDGES_PER_FRAME)) begin
               lm.nibble[g] = lm.word[FRAME_W - LANES * (int'(lm.edge_idx) + 1) + g];
            end else begin
               lm.nibble[g] = 1'b0;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// file: hw/rrdbg_serializer.sv
// Raw sample debug serializer: packs four 12-bit channel samples per frame onto four lanes.
// Assumes samples arrive from logic on the same clock; rate_sel is steady or changes
// only between frames.
`default_nettype none
module rrdbg_serializer
   import rrdbg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Sample input stream
   input wire logic [SAMPLE_W-1:0] sample_data,
   input wire logic sample_valid,
   output logic sample_ready,
   // Rate selection
   input wire logic [1:0] rate_sel,
   // Debug port pins
   output logic port_bit_clock_pin,
   output logic frame_clock_pin,
   output logic [LANES-1:0] sample_data_lanes
);
   rrdbg_state_t state_q, state_d;
   logic ph_q, ph_d;
   logic bclk_q, bclk_d;
   logic frm_q, frm_d;
   logic [LANES-1:0] lanes_q, lanes_d;
   logic [3:0] edge_q, edge_d;
   logic [4:0] gap_q, gap_d;
   logic [FRAME_W-1:0] buf_q, buf_d;
   logic [FRAME_W-1:0] word_q, word_d;
   logic [2:0] cnt_q, cnt_d;
   logic [4:0] gap_sel;
   logic accept;
   logic last_slot;
   logic start;
   rrdbg_lane_if lif ();

   rrdbg_lane_mux u_mux (
      .lm (lif.mux)
   );

   always_comb begin
      unique case (rrdbg_rate_t'(rate_sel))
         RRDBG_RATE_400: gap_sel = GAP_400;
         RRDBG_RATE_320: gap_sel = GAP_320;
         RRDBG_RATE_200: gap_sel = GAP_200;
         RRDBG_RATE_160: gap_sel = GAP_160;
      endcase
   end

   // Slot boundary is ph_q high; the bit clock moves one cycle later, mid-bit
   assign sample_ready = cnt_q != FULL_COUNT;
   assign accept = sample_valid && sample_ready;
   assign last_slot = state_q == RRDBG_SEND && edge_q == LAST_EDGE;
   // Only a slot whose bit clock edge rises may open a frame
   assign start = ph_q && !bclk_q && cnt_q == FULL_COUNT &&
                  (state_q == RRDBG_IDLE || (last_slot && gap_sel == GAP_400));

   always_comb begin
      lif.word = start ? buf_q : word_q;
      lif.edge_idx = start ? 4'h0 : edge_q + 4'h1;
   end

   always_comb begin
      ph_d = ~ph_q;
      bclk_d = ph_q ? bclk_q : ~bclk_q;
      state_d = state_q;
      frm_d = frm_q;
      lanes_d = lanes_q;
      edge_d = edge_q;
      gap_d = gap_q;
      word_d = word_q;
      buf_d = buf_q;
      cnt_d = cnt_q;
      if (accept) begin
         // Channels fill the word in arrival order, first one at the top
         buf_d[FRAME_W - 1 - SAMPLE_W * int'(cnt_q) -: SAMPLE_W] = sample_data;
         cnt_d = cnt_q + 3'h1;
      end
      if (start) begin
         word_d = buf_q;
         cnt_d = 3'h0;
         state_d = RRDBG_SEND;
         edge_d = 4'h0;
         lanes_d = lif.nibble;
         frm_d = 1'b1;
      end else if (ph_q) begin
         unique case (state_q)
            RRDBG_IDLE: begin
               lanes_d = LANES_IDLE;
               frm_d = 1'b0;
            end
            RRDBG_SEND: begin
               if (last_slot) begin
                  lanes_d = LANES_IDLE;
                  frm_d = 1'b0;
                  // A frame ends after exactly twelve edges
                  state_d = gap_sel == GAP_400 ? RRDBG_IDLE : RRDBG_GAP;
                  // This slot is already the first idle edge and one more passes in GAP at count zero,
                  // so load two less; nonzero gap codes must therefore be two or more
                  gap_d = gap_sel - 5'h2;
               end else begin
                  edge_d = edge_q + 4'h1;
                  lanes_d = lif.nibble;
                  frm_d = lif.edge_idx < 4'(FRAME_HIGH_EDGES);
               end
            end
            RRDBG_GAP: begin
               // Gap keeps lanes and frame clock low while the bit clock keeps running
               lanes_d = LANES_IDLE;
               frm_d = 1'b0;
               if (gap_q == 5'h0) begin
                  state_d = RRDBG_IDLE;
               end else begin
                  gap_d = gap_q - 5'h1;
               end
            end
            default: state_d = RRDBG_IDLE;
         endcase
      end
      if (start && accept) begin
         // The new sample lands in the freed buffer, not the word now leaving
         buf_d[FRAME_W - 1 -: SAMPLE_W] = sample_data;
         cnt_d = 3'h1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= RRDBG_IDLE;
         ph_q <= 1'b0;
         bclk_q <= 1'b0;
         frm_q <= 1'b0;
         lanes_q <= LANES_IDLE;
         edge_q <= 4'h0;
         gap_q <= 5'h00;
         buf_q <= '0;
         word_q <= '0;
         cnt_q <= 3'h0;
      end else begin
         state_q <= state_d;
         ph_q <= ph_d;
         bclk_q <= bclk_d;
         frm_q <= frm_d;
         lanes_q <= lanes_d;
         edge_q <= edge_d;
         gap_q <= gap_d;
         buf_q <= buf_d;
         word_q <= word_d;
         cnt_q <= cnt_d;
      end
   end

   assign port_bit_clock_pin = bclk_q;
   assign frame_clock_pin = frm_q;
   assign sample_data_lanes = lanes_q;

   // Checks
   logic [4:0] hi_cnt_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hi_cnt_q <= 5'h00;
      end else begin
         hi_cnt_q <= frm_q ? hi_cnt_q + 5'h1 : 5'h00;
      end
   end

   sequence s_frame_open;
      !frm_q ##1 frm_q;
   endsequence

   sequence s_high_half;
      frm_q [*8] ##1 frm_q [*4];
   endsequence

   a_bclk_runs: assert property (@(posedge clk) disable iff (!nrst)
      !ph_q |=> (bclk_q != $past(bclk_q)))
      else $error("bit clock missed a toggle");

   a_bclk_period: assert property (@(posedge clk) disable iff (!nrst)
      $rose(bclk_q) |-> ##4 $rose(bclk_q))
      else $error("bit clock period is not four cycles");

   a_frame_rise: assert property (@(posedge clk) disable iff (!nrst)
      s_frame_open |-> ##1 $rose(bclk_q))
      else $error("frame did not open on a rising bit clock edge");

   a_frame_high: assert property (@(posedge clk) disable iff (!nrst)
      s_frame_open |-> s_high_half ##1 !frm_q)
      else $error("frame clock high phase not six edges");

   a_frame_len: assert property (@(posedge clk) disable iff (!nrst)
      hi_cnt_q <= 5'h0c)
      else $error("frame clock high too long");

   a_lanes_stable: assert property (@(posedge clk) disable iff (!nrst)
      !ph_q |=> $stable(sample_data_lanes) && $stable(frame_clock_pin))
      else $error("lanes moved on a bit clock edge");

   a_gap_idle: assert property (@(posedge clk) disable iff (!nrst)
      state_q == RRDBG_GAP |-> sample_data_lanes == LANES_IDLE && !frame_clock_pin)
      else $error("lanes not idle during gap");

   a_first_nibble: assert property (@(posedge clk) disable iff (!nrst)
      start |=> sample_data_lanes == $past(buf_q[FRAME_W-1 -: LANES]))
      else $error("first edge does not carry top nibble");

   a_ready_full: assert property (@(posedge clk) disable iff (!nrst)
      cnt_q == FULL_COUNT && !start |=> !sample_ready || $past(start))
      else $error("ready while buffer full");

   a_gap_length: assert property (@(posedge clk) disable iff (!nrst)
      $fell(frm_q) && gap_sel == GAP_160 && $stable(rate_sel) && state_q == RRDBG_SEND
      |-> !frm_q [*8] ##1 !frm_q [*8])
      else $error("gap shorter than selected rate allows");
endmodule
`default_nettype wire

// file: inc/rrdbg_lane_if.sv
// Carrier between the serializer and its lane multiplexer.
// Assumes both ends sit in the same clock domain; the signals are combinational.
`default_nettype none
interface rrdbg_lane_if;
   import rrdbg_pkg::*;
   logic [FRAME_W-1:0] word;
   logic [3:0] edge_idx;
   logic [LANES-1:0] nibble;
   modport ctrl (output word, output edge_idx, input nibble);
   modport mux (input word, input edge_idx, output nibble);
endinterface
`default_nettype wire

// file: inc/rrdbg_pkg.sv
// Constants and types for the raw sample debug serializer.
// Assumes one 10 MHz system clock and an active-low asynchronous reset.
`default_nettype none
package rrdbg_pkg;
   // Port shape
   localparam int LANES = 4;
   localparam int SAMPLE_W = 12;
   localparam int EDGES_PER_SAMPLE = SAMPLE_W / LANES;
   localparam int EDGES_PER_FRAME = 12;
   localparam int SAMPLES_PER_FRAME = EDGES_PER_FRAME / EDGES_PER_SAMPLE;
   localparam int FRAME_W = EDGES_PER_FRAME * LANES;
   localparam int FRAME_HIGH_EDGES = EDGES_PER_FRAME / 2;
   localparam logic [3:0] LAST_EDGE = 4'hb;
   localparam logic [2:0] FULL_COUNT = 3'h4;
   // Each bit slot lasts two system clocks so the data is steady around each bit clock edge
   localparam int CLK_PERIOD_PS = 100000;
   localparam int BIT_MIN_PS = 9600;
   localparam int SLOT_CYC = ((BIT_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 2 ? 2 :
                             ((BIT_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   // Idle edges after a frame so the port rate matches the selected aggregate rate, except 320, whose 3 idle edges round up to 4 (16-edge frame period)
   typedef enum logic [1:0] {RRDBG_RATE_400, RRDBG_RATE_320, RRDBG_RATE_200,
                             RRDBG_RATE_160} rrdbg_rate_t;
   localparam logic [4:0] GAP_400 = 5'h00;
   localparam logic [4:0] GAP_320 = 5'h03;
   localparam logic [4:0] GAP_200 = 5'h0c;
   localparam logic [4:0] GAP_160 = 5'h12;
   localparam logic [LANES-1:0] LANES_IDLE = 4'h0;
   typedef enum logic [1:0] {RRDBG_IDLE, RRDBG_SEND, RRDBG_GAP} rrdbg_state_t;
endpackage
`default_nettype wire
